// ===== sfs_frontend.sv
`timescale 1ns/1ps
`include "sfs_regs.svh"
module sfs_frontend
  import sfs_pkg::*;
#(
  parameter int SECTORS = `SFS_SECTORS
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic wp_b_in,
  input wire logic reset_b_in,
  // decoder feedback: classify the opcode byte just taken
  input wire logic [1:0] op_kind_in,
  input wire logic [4:0] op_sector_in,
  input wire logic busy_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic sw_prot_en_in,
  input wire logic [SECTORS-1:0] prot_map_in,
  output logic so_out,
  output logic so_oe_b_out,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic [1:0] rx_phase_out,
  output logic op_start_out,
  output logic op_end_out,
  output logic op_block_out,
  output logic prot_wr_ok_out,
  output logic standby_out,
  output logic rd_req_out
);
  ////////////////////////////////////////////////////////////////////////
  logic cs_m_reg, cs_s_reg, cs_d_reg;
  logic sck_m_reg, sck_s_reg, sck_d_reg;
  logic si_m_reg, si_s_reg, wp_m_reg, wp_s_reg, rst_m_reg, rst_s_reg;
  logic [7:0] shift_reg, tx_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] addr_cnt_reg;
  sfs_phase_e phase_reg;
  logic pend_reg;
  logic run_b;
  logic cs_fall, cs_rise, sck_rise, sck_fall, sel;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      {cs_m_reg, cs_s_reg, cs_d_reg} <= 3'h7;
      {sck_m_reg, sck_s_reg, sck_d_reg} <= 3'h0;
      {si_m_reg, si_s_reg} <= 2'h0;
      {wp_m_reg, wp_s_reg} <= 2'h3;
      {rst_m_reg, rst_s_reg} <= 2'h0;
    end else begin
      cs_m_reg <= cs_b_in;
      cs_s_reg <= cs_m_reg;
      cs_d_reg <= cs_s_reg;
      sck_m_reg <= sck_in;
      sck_s_reg <= sck_m_reg;
      sck_d_reg <= sck_s_reg;
      si_m_reg <= si_in;
      si_s_reg <= si_m_reg;
      wp_m_reg <= wp_b_in;
      wp_s_reg <= wp_m_reg;
      rst_m_reg <= reset_b_in;
      rst_s_reg <= rst_m_reg;
    end
  end

  assign run_b = rst_b_in && rst_s_reg;
  assign cs_fall = cs_d_reg && !cs_s_reg;
  assign cs_rise = !cs_d_reg && cs_s_reg;
  assign sel = !cs_s_reg && !cs_d_reg;
  // edges only count while selected, so either idle level works
  assign sck_rise = sel && !sck_d_reg && sck_s_reg;
  assign sck_fall = sel && sck_d_reg && !sck_s_reg;

  ////////////////////////////////////////////////////////////////////////
  // receive path
  always_ff @(posedge clk_in) begin
    if (!run_b || cs_fall) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rx_valid_out <= 1'b0;
      rx_byte_out <= 8'h00;
    end else if (cs_s_reg) begin
      bit_cnt_reg <= 4'h0;
      rx_valid_out <= 1'b0;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[6:0], si_s_reg};
      if (bit_cnt_reg == `SFS_BYTE_BITS - 4'h1) begin
        bit_cnt_reg <= 4'h0;
        rx_byte_out <= {shift_reg[6:0], si_s_reg};
        rx_valid_out <= 1'b1;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        rx_valid_out <= 1'b0;
      end
    end else begin
      rx_valid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command phase and protection
  always_ff @(posedge clk_in) begin
    if (!run_b) begin
      phase_reg <= SFS_IDLE;
      addr_cnt_reg <= 3'h0;
      op_block_out <= 1'b0;
    end else if (cs_fall) begin
      phase_reg <= SFS_OPCODE;
      addr_cnt_reg <= 3'h0;
      op_block_out <= 1'b0;
    end else if (cs_rise) begin
      phase_reg <= SFS_IDLE;
      op_block_out <= 1'b0;
    end else if (rx_valid_out) begin
      case (phase_reg)
        SFS_OPCODE: begin
          phase_reg <= SFS_ADDR;
          // sector known here from the decoder; protect-type ops still run
          op_block_out <= !wp_s_reg && op_kind_in == SFS_OP_PROG &&
            prot_map_in[op_sector_in[3:0]];
        end
        SFS_ADDR: begin
          if (addr_cnt_reg == `SFS_ADDR_BYTES - 3'h1) begin
            phase_reg <= SFS_DATA;
          end
          addr_cnt_reg <= addr_cnt_reg + 3'h1;
        end
        default: phase_reg <= phase_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!run_b) begin
      prot_wr_ok_out <= 1'b0;
      op_start_out <= 1'b0;
      op_end_out <= 1'b0;
      rx_phase_out <= 2'h0;
    end else begin
      prot_wr_ok_out <= wp_s_reg;
      op_start_out <= cs_fall;
      op_end_out <= cs_rise;
      rx_phase_out <= phase_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit path: next bit is set up on falling edge
  always_ff @(posedge clk_in) begin
    if (!run_b) begin
      tx_reg <= 8'h00;
      so_out <= 1'b0;
      rd_req_out <= 1'b0;
    end else if (cs_fall) begin
      // bit held: output only moves on a falling serial clock edge
      tx_reg <= 8'h00;
      rd_req_out <= 1'b0;
    end else if (sck_fall && phase_reg == SFS_DATA) begin
      so_out <= (bit_cnt_reg == 4'h0) ? rd_byte_in[7] : tx_reg[7];
      tx_reg <= (bit_cnt_reg == 4'h0) ? {rd_byte_in[6:0], 1'b0} :
        {tx_reg[6:0], 1'b0};
      rd_req_out <= bit_cnt_reg == 4'h0;
    end else begin
      rd_req_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!run_b) begin
      so_oe_b_out <= 1'b1;
    end else begin
      so_oe_b_out <= cs_s_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (!run_b) begin
      pend_reg <= 1'b0;
      standby_out <= 1'b1;
    end else begin
      pend_reg <= busy_in;
      standby_out <= cs_s_reg && !busy_in && !pend_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (!run_b);

  AST_SO_RELEASED: assert property (
    cs_s_reg |=> so_oe_b_out)
    else $error("serial output driven while deselected");
  AST_NO_STANDBY_BUSY: assert property (
    busy_in |=> !standby_out)
    else $error("standby entered during self-timed cycle");
  AST_NO_RX_DESEL: assert property (
    cs_s_reg |=> !rx_valid_out)
    else $error("byte captured while deselected");
  AST_CNT_CLEAR: assert property (
    cs_fall |=> bit_cnt_reg == 4'h0 && phase_reg == SFS_OPCODE)
    else $error("state not cleared on select");
  AST_BYTE_MSB: assert property (
    sck_rise && bit_cnt_reg == 4'h7 && !cs_s_reg |=>
      rx_valid_out && rx_byte_out[0] == $past(si_s_reg))
    else $error("byte not assembled msb first");
  AST_SO_ON_FALL: assert property (
    !sck_fall && $past(!sck_fall) |=> $stable(so_out))
    else $error("output changed off a falling edge");
  AST_PROT_LOCK: assert property (
    !wp_s_reg |=> !prot_wr_ok_out)
    else $error("protection write allowed under protect pin");
  AST_BLOCK_END: assert property (
    cs_rise |=> !op_block_out && phase_reg == SFS_IDLE)
    else $error("block not released at deselect");
  AST_ADDR_TO_DATA: assert property (
    phase_reg == SFS_ADDR && rx_valid_out && addr_cnt_reg == 3'h2 &&
      !cs_rise |=> phase_reg == SFS_DATA)
    else $error("address phase length wrong");
  AST_START_PULSE: assert property (
    cs_fall |=> op_start_out ##1 !op_start_out)
    else $error("start pulse wrong");
  AST_HW_BLOCK: assert property (
    rx_valid_out && phase_reg == SFS_OPCODE && !wp_s_reg && !cs_rise &&
      op_kind_in == SFS_OP_PROG && prot_map_in[op_sector_in[3:0]] |=>
      op_block_out)
    else $error("flagged sector not blocked under protect pin");
  AST_NO_BLOCK_FREE: assert property (
    rx_valid_out && phase_reg == SFS_OPCODE &&
      (wp_s_reg || op_kind_in != SFS_OP_PROG) |=> !op_block_out)
    else $error("command blocked without protect pin or program kind");

  COV_BYTE: cover property (rx_valid_out && phase_reg == SFS_OPCODE);
  COV_DATA: cover property (phase_reg == SFS_DATA && rd_req_out);
  COV_BLOCKED: cover property (op_block_out);
  COV_BUSY_DESEL: cover property (cs_s_reg && busy_in ##1 !busy_in);
  // pin alone blocks, with the software enable off
  COV_HW_ONLY: cover property (op_block_out && !sw_prot_en_in);
endmodule

// ===== sfs_frontend_bench.sv
`timescale 1ns/1ps
module sfs_frontend_bench;
  import sfs_pkg::*;
  logic clk_in, rst_b_in, cs_b_in, sck_in, si_in, wp_b_in, reset_b_in;
  logic busy_in, sw_prot_en_in, so_out, so_oe_b_out, rx_valid_out;
  logic op_start_out, op_end_out, op_block_out, prot_wr_ok_out;
  logic standby_out, rd_req_out;
  logic [1:0] op_kind_in, rx_phase_out;
  logic [4:0] op_sector_in;
  logic [7:0] rd_byte_in, rx_byte_out, last_rx, got;
  logic [15:0] prot_map_in;
  int n_rx = 0;
  int n_st = 0;
  int n_rd = 0;
  int n_end = 0;
  int n_errors = 0;
  int check_count = 0;
  sfs_frontend dut (.clk_in, .rst_b_in, .cs_b_in, .sck_in, .si_in,
    .wp_b_in, .reset_b_in, .op_kind_in, .op_sector_in, .busy_in,
    .rd_byte_in, .sw_prot_en_in, .prot_map_in, .so_out, .so_oe_b_out,
    .rx_byte_out, .rx_valid_out, .rx_phase_out, .op_start_out,
    .op_end_out, .op_block_out, .prot_wr_ok_out, .standby_out,
    .rd_req_out);
  // released output shows the inverse so a stale bit cannot pass
  sfs_host host (.clk_in, .so_in(so_oe_b_out ? ~so_out : so_out),
    .cs_b_out(cs_b_in),
    .sck_out(sck_in), .si_out(si_in), .got_out(got));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (rx_valid_out === 1'b1) begin
      last_rx <= rx_byte_out;
      n_rx <= n_rx + 1;
    end
    if (op_start_out === 1'b1) n_st <= n_st + 1;
    if (rd_req_out === 1'b1) n_rd <= n_rd + 1;
    if (op_end_out === 1'b1) n_end <= n_end + 1;
  end
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic t_read();
    int s, r, e;
    s = n_st;
    r = n_rd;
    e = n_end;
    op_kind_in = SFS_OP_PROG;
    host.sel(1'b0);
    chk(so_oe_b_out === 1'b0 && n_st == s + 1, "select");
    host.xfer(8'hA5, 8);
    repeat (2) @(negedge clk_in);
    chk(last_rx === 8'hA5, "opcode byte");
    chk(op_block_out === 1'b0, "no block with pin high");
    repeat (3) host.xfer(8'h00, 8);
    host.xfer(8'h00, 8);
    chk(got === 8'hC3, "read byte");
    chk(rx_phase_out === SFS_DATA, "phase");
    host.desel();
    chk(so_oe_b_out === 1'b1 && standby_out === 1'b1, "idle");
    chk(n_rd == r + 2 && n_end == e + 1, "fetches and end");
  endtask
  task automatic t_partial();
    int n;
    host.sel(1'b1);
    host.xfer(8'hFF, 3);
    host.desel();
    n = n_rx;
    host.sel(1'b1);
    host.xfer(8'h3C, 8);
    host.desel();
    chk(last_rx === 8'h3C && n_rx == n + 1, "mode 3 byte");
  endtask
  task automatic t_protect();
    wp_b_in = 1'b0;
    op_kind_in = SFS_OP_PROG;
    repeat (4) @(negedge clk_in);
    chk(prot_wr_ok_out === 1'b0, "prot locked");
    host.sel(1'b0);
    host.xfer(8'h82, 8);
    repeat (2) @(negedge clk_in);
    chk(op_block_out === 1'b1, "blocked");
    busy_in = 1'b1;
    host.desel();
    chk(standby_out === 1'b0, "busy standby");
    busy_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(standby_out === 1'b1, "standby");
    op_sector_in = 5'h04;
    host.sel(1'b0);
    host.xfer(8'h82, 8);
    repeat (2) @(negedge clk_in);
    chk(op_block_out === 1'b0, "unflagged sector");
    host.desel();
    op_sector_in = 5'h03;
    op_kind_in = SFS_OP_PROT;
    sw_prot_en_in = 1'b1;
    host.sel(1'b0);
    host.xfer(8'h3D, 8);
    repeat (2) @(negedge clk_in);
    chk(op_block_out === 1'b0, "prot cmd runs");
    chk(prot_wr_ok_out === 1'b0, "prot locked with sw on");
    reset_b_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk(so_oe_b_out === 1'b1 && rx_phase_out === SFS_IDLE, "abort");
    reset_b_in = 1'b1;
    wp_b_in = 1'b1;
    host.desel();
    chk(prot_wr_ok_out === 1'b1, "prot free");
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    {rst_b_in, busy_in, sw_prot_en_in} = 3'h0;
    {wp_b_in, reset_b_in} = 2'h3;
    op_kind_in = SFS_OP_OTHER;
    op_sector_in = 5'h03;
    prot_map_in = 16'h0008;
    rd_byte_in = 8'hC3;
    repeat (10) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(so_oe_b_out === 1'b1 && standby_out === 1'b1, "reset");
    t_read();
    t_partial();
    t_protect();
    report_and_stop();
  end
endmodule

// ===== sfs_host.sv
`timescale 1ns/1ps
module sfs_host (
  input wire logic clk_in,
  input wire logic so_in,
  output logic cs_b_out,
  output logic sck_out,
  output logic si_out,
  output logic [7:0] got_out
);
  logic m3_reg;
  initial begin
    cs_b_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    got_out = 8'h00;
    m3_reg = 1'b0;
  end
  // clock idle level at the select edge picks the mode
  task automatic sel(input logic m3);
    @(negedge clk_in) sck_out = m3;
    m3_reg = m3;
    repeat (8) @(negedge clk_in);
    cs_b_out = 1'b0;
    repeat (8) @(negedge clk_in);
  endtask
  task automatic xfer(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      if (m3_reg) sck_out = 1'b0;
      si_out = b[i];
      repeat (8) @(negedge clk_in);
      sck_out = 1'b1;
      got_out = {got_out[6:0], so_in};
      repeat (8) @(negedge clk_in);
      if (!m3_reg) sck_out = 1'b0;
    end
  endtask
  // serial input keeps toggling after deselect, which the device must ignore
  task automatic desel();
    repeat (8) @(negedge clk_in);
    cs_b_out = 1'b1;
    repeat (16) @(negedge clk_in) si_out = ~si_out;
  endtask
endmodule

// ===== sfs_pkg.sv
package sfs_pkg;
  typedef enum logic [1:0] {
    SFS_IDLE = 2'b00,
    SFS_OPCODE = 2'b01,
    SFS_ADDR = 2'b10,
    SFS_DATA = 2'b11
  } sfs_phase_e;
  typedef enum logic [1:0] {
    SFS_OP_OTHER = 2'b00,
    SFS_OP_PROG = 2'b01,
    SFS_OP_PROT = 2'b10
  } sfs_kind_e;
endpackage

// ===== sfs_regs.svh
// Contract
// - operations start on chip select falling edge and end on its rising edge
// - deselected means standby, serial output released to high impedance
// - a self-timed program or erase keeps running; standby only after it ends
// - serial input is ignored whenever chip select is high
// - command, address and write data captured on rising serial clock edges
// - serial output bit changes on falling serial clock edges
// - host may use mode 0 or mode 3
// - write-protect low makes flagged sectors reject program and erase
// - hardware protection never touches the software protection enable
// - while write-protect is low the protection register cannot change
// - 8-bit opcode then address bytes, most significant bit first
// - program or erase under write-protect ignored; protect commands still run; code blocks only SFS_OP_PROG to sectors flagged in prot_map_in
// - reset low aborts work and holds the state machine idle
// - three address bytes follow the opcode
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH
`define SFS_ADDR_BYTES 3'h3
`define SFS_BYTE_BITS 4'h8
`define SFS_SECTORS 16
`endif
